/* File: hw/mio_ctl.sv */
`timescale 1ns/1ps
`default_nettype none
`include "mio_defs.svh"

// Notes on behaviour
// - Pulse power-on preset on power switching on or off and on preset button.
// - Assert control reset when clear-control addresses select code 00.
// - Hold run line true while the computer is in run mode.
// - Power-on line true only while supplies are at operating level.
// - Computer vectors the interrupt to the reported six-bit address.
// - Sixteen buffered two-way data lines, wired-OR among devices.
// - Output strobe enables outgoing data, held from phase three to five.
// - Input strobe enables receivers; addressed device drives data then.
// - Unconnected power-fail input reads high, needing no inactive level.
// - Select, vector, interrupt and power-fail lines are ground-true.
module mio_ctl
  import mio_pkg::*;
(
  // Clock, reset, enable
  input wire logic CLOCK,
  input wire logic RST,
  input wire logic CE,
  // Computer side instruction decode
  input wire logic IO_GROUP,
  input wire logic INSTR_OUT,
  input wire logic INSTR_IN,
  input wire logic INSTR_CLC,
  input wire logic [5:0] SEL_CODE,
  input wire logic [2:0] PHASE,
  input wire logic INT_PHASE,
  input wire logic RUN_MODE,
  input wire logic POWER_OK,
  input wire logic [15:0] CPU_DATA_OUT,
  // Pins from the controller
  input wire logic PRESET_BUTTON,
  input wire logic [15:0] IO_BUS_I,
  input wire logic [5:0] IRQ_VECTOR_BITS_N,
  input wire logic EXT_IRQ_REQUEST_N,
  input wire logic EXT_POWER_FAIL_N,
  // Select lines to the controller
  output logic [7:0] SELECT_HIGH_DIGIT_N,
  output logic [7:0] SELECT_LOW_DIGIT_N,
  output logic IO_GROUP_STROBE,
  // Data card strobes and bus
  output logic OUTPUT_STROBE,
  output logic INPUT_STROBE,
  output logic [15:0] IO_BUS_O,
  output logic IO_BUS_OE,
  // General control
  output logic CONTROL_RESET,
  output logic PRESET_PULSE,
  output logic RUN,
  output logic POWER_ON,
  // Interrupt and power fail to the computer
  output logic [5:0] INT_ADDR,
  output logic INT_VALID,
  output logic IRQ_PENDING,
  output logic PF_HALT,
  output logic AUTO_RESTART_EN
);

  mio_state_t st;
  mio_state_t next_st;
  logic [`MIO_PIN_W-1:0] pins;
  logic [`MIO_PIN_W-1:0] pins_s;
  logic [15:0] bus_s;
  logic [5:0] vec_s;
  logic irq_s;
  logic pf_s;
  logic btn_s;
  logic in_window;
  logic preset_trig;

  assign pins = {PRESET_BUTTON, EXT_POWER_FAIL_N, EXT_IRQ_REQUEST_N,
                 IRQ_VECTOR_BITS_N, IO_BUS_I};

  // Every pin input crosses two flops before use
  mio_sync #(
    .WIDTH(`MIO_PIN_W),
    .RESET_VAL(`MIO_PIN_RESET)
  ) u_sync (
    .clk(CLOCK),
    .rst(RST),
    .ce(CE),
    .d(pins),
    .q(pins_s)
  );

  // Ground-true vector and request pins become active high here; power fail stays low-true
  assign bus_s = pins_s[`MIO_PIN_BUS_LSB +: 16];
  assign vec_s = ~pins_s[`MIO_PIN_VEC_LSB +: 6];
  assign irq_s = ~pins_s[`MIO_PIN_IRQ];
  assign pf_s = pins_s[`MIO_PIN_PF];
  assign btn_s = pins_s[`MIO_PIN_BTN];

  assign in_window = (PHASE >= `MIO_PHASE_THREE) && (PHASE <= `MIO_PHASE_FIVE);
  assign preset_trig = (POWER_OK != st.pwr_prev) || (btn_s && !st.btn_prev);

  always_comb begin
    next_st = st;
    next_st.pwr_prev = POWER_OK;
    next_st.btn_prev = btn_s;

    // Select digits pulled low only under the group strobe
    next_st.io_group_strobe = IO_GROUP;
    if (IO_GROUP) begin
      next_st.sel_high_n = ~(8'h01 << SEL_CODE[5:3]);
      next_st.sel_low_n = ~(8'h01 << SEL_CODE[2:0]);
    end else begin
      next_st.sel_high_n = 8'hFF;
      next_st.sel_low_n = 8'hFF;
    end

    next_st.ctl_reset = IO_GROUP && INSTR_CLC && (SEL_CODE == `MIO_CLEAR_ALL_CODE);

    // Power switching either way or the button restarts the pulse
    if (preset_trig) begin
      next_st.preset_cnt = `MIO_PRESET_CYCLES;
    end else if (st.preset_cnt != 4'h0) begin
      next_st.preset_cnt = st.preset_cnt - 4'h1;
    end
    next_st.preset = (next_st.preset_cnt != 4'h0);

    next_st.run = RUN_MODE;
    next_st.pwr_on = POWER_OK;

    // Output data latched at phase three, driven until phase five ends
    next_st.out_stb = IO_GROUP && INSTR_OUT && in_window;
    next_st.bus_oe = next_st.out_stb;
    if (IO_GROUP && INSTR_OUT && (PHASE == `MIO_PHASE_THREE)) begin
      next_st.bus_o = CPU_DATA_OUT;
    end

    // Input sampled late in phase five so the bus has settled
    next_st.in_stb = IO_GROUP && INSTR_IN && in_window;
    if (st.in_stb && (PHASE == `MIO_PHASE_FIVE)) begin
      next_st.cpu_din = bus_s;
    end

    // A request with a reserved high digit is not a device
    next_st.irq_pending = irq_s && (vec_s[5:3] != `MIO_RESERVED_HIGH);
    next_st.int_valid = 1'b0;
    if (INT_PHASE && st.irq_pending) begin
      next_st.int_addr = vec_s;
      next_st.int_valid = 1'b1;
    end

    // Low inhibits restart; unconnected pin idles high
    next_st.pf_halt = !pf_s;
    next_st.restart_en = pf_s;
  end

  always_ff @(posedge CLOCK) begin
    if (RST) begin
      st <= '0;
      st.sel_high_n <= 8'hFF;
      st.sel_low_n <= 8'hFF;
      st.restart_en <= 1'b1;
    end else if (CE) begin
      st <= next_st;
    end
  end

  assign SELECT_HIGH_DIGIT_N = st.sel_high_n;
  assign SELECT_LOW_DIGIT_N = st.sel_low_n;
  assign IO_GROUP_STROBE = st.io_group_strobe;
  assign OUTPUT_STROBE = st.out_stb;
  assign INPUT_STROBE = st.in_stb;
  assign IO_BUS_O = st.bus_o;
  assign IO_BUS_OE = st.bus_oe;
  assign CONTROL_RESET = st.ctl_reset;
  assign PRESET_PULSE = st.preset;
  assign RUN = st.run;
  assign POWER_ON = st.pwr_on;
  assign INT_ADDR = st.int_addr;
  assign INT_VALID = st.int_valid;
  assign IRQ_PENDING = st.irq_pending;
  assign PF_HALT = st.pf_halt;
  assign AUTO_RESTART_EN = st.restart_en;

  // Probe point for the captured input word
  logic [15:0] cpu_din_q;
  assign cpu_din_q = st.cpu_din;

  default clocking cb @(posedge CLOCK);
  endclocking
  default disable iff (RST);

  sequence out_begin_s;
    CE && IO_GROUP && INSTR_OUT && (PHASE == `MIO_PHASE_THREE);
  endsequence

  sequence out_drive_s;
    OUTPUT_STROBE && IO_BUS_OE;
  endsequence

  preset_on_power_a: assert property (CE && (POWER_OK != st.pwr_prev)
    |=> PRESET_PULSE [*1] ##0 (st.preset_cnt == `MIO_PRESET_CYCLES))
    else $error("preset pulse missing after power change");

  clear_all_a: assert property (
    CE && IO_GROUP && INSTR_CLC && (SEL_CODE == `MIO_CLEAR_ALL_CODE) |=> CONTROL_RESET)
    else $error("control reset missing on clear of code 00");

  run_follow_a: assert property (CE |=> (RUN == $past(RUN_MODE)))
    else $error("run line does not follow run mode");

  power_drop_a: assert property (CE && !POWER_OK |=> !POWER_ON)
    else $error("power-on line stays true after supply loss");

  vector_report_a: assert property (CE && INT_PHASE && IRQ_PENDING
    |=> INT_VALID && (INT_ADDR == $past(vec_s)))
    else $error("interrupt address not reported");

  out_window_a: assert property (out_begin_s |=> out_drive_s
    ##0 (IO_BUS_O == $past(CPU_DATA_OUT)))
    else $error("output strobe or data missing at phase three");

  out_close_a: assert property (CE && !in_window |=> !OUTPUT_STROBE && !IO_BUS_OE)
    else $error("output strobe held outside phases three to five");

  in_capture_a: assert property (CE && INPUT_STROBE && (PHASE == `MIO_PHASE_FIVE)
    |=> (cpu_din_q == $past(bus_s)))
    else $error("input data not captured at phase five");

  pf_idle_a: assert property (CE && pf_s |=> !PF_HALT && AUTO_RESTART_EN)
    else $error("power fail acts while the line is high");

endmodule

`default_nettype wire

/* File: hw/mio_defs.svh */
`ifndef MIO_DEFS_SVH
`define MIO_DEFS_SVH

// Data path and pin vector widths
`define MIO_DATA_W 16
`define MIO_VEC_W 6
`define MIO_PIN_W 25

// Positions inside the synchronised pin vector
`define MIO_PIN_BUS_LSB 0
`define MIO_PIN_VEC_LSB 16
`define MIO_PIN_IRQ 22
`define MIO_PIN_PF 23
`define MIO_PIN_BTN 24

// Active-low pins idle high after reset, the rest idle low
`define MIO_PIN_RESET 25'h0FF0000

// Phase codes of the I/O cycle
`define MIO_PHASE_THREE 3'h3
`define MIO_PHASE_FIVE 3'h5

// Select code that clears control on every device
`define MIO_CLEAR_ALL_CODE 6'h00
// Most significant digit reserved for mainframe codes
`define MIO_RESERVED_HIGH 3'h0

// Length of the power-on preset pulse in clock cycles
`define MIO_PRESET_CYCLES 4'h4

`endif

/* File: hw/mio_pkg.sv */
package mio_pkg;

  typedef struct packed {
    logic [7:0] sel_high_n;
    logic [7:0] sel_low_n;
    logic io_group_strobe;
    logic out_stb;
    logic in_stb;
    logic [15:0] bus_o;
    logic bus_oe;
    logic [15:0] cpu_din;
    logic ctl_reset;
    logic [3:0] preset_cnt;
    logic preset;
    logic pwr_prev;
    logic btn_prev;
    logic run;
    logic pwr_on;
    logic [5:0] int_addr;
    logic int_valid;
    logic irq_pending;
    logic pf_halt;
    logic restart_en;
  } mio_state_t;

endpackage

/* File: hw/mio_sync.sv */
`timescale 1ns/1ps
`default_nettype none

module mio_sync #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
  // Clock, reset, enable
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  // Pins in, synchronised out
  input wire logic [WIDTH-1:0] d,
  output logic [WIDTH-1:0] q
);

  logic [WIDTH-1:0] meta;

  // First stage feeds only the second stage
  always_ff @(posedge clk) begin
    if (rst) begin
      meta <= RESET_VAL;
      q <= RESET_VAL;
    end else if (ce) begin
      meta <= d;
      q <= meta;
    end
  end

endmodule

`default_nettype wire

/* File: sim/mio_partner.sv */
`timescale 1ns/1ps
`default_nettype none

module mio_partner #(
  parameter logic [15:0] DEV_DATA = 16'hC35A
) (
  // Strobe and select from the controller
  input wire logic in_stb,
  input wire logic [7:0] sel_high_n,
  // Scenario controls
  input wire logic [5:0] irq_code,
  input wire logic irq_on,
  input wire logic pf_low,
  // Pins back to the control card
  output logic [5:0] vec_n,
  output logic irq_n,
  output logic pf_n,
  output logic [15:0] bus
);
  // One buffered line feeds at most eight cards; chain settles in a cycle
  logic [8:0] prio_chain;
  // Each card's priority out feeds the next; short chain needs no look-ahead
  always_comb begin
    prio_chain[0] = 1'b1;
    for (int i = 0; i < 8; i++) begin
      prio_chain[i + 1] = prio_chain[i] && !(irq_on && (irq_code[5:3] == i[2:0]));
    end
  end
  // Vector stays put for as long as the request stands
  assign vec_n = irq_on ? ~irq_code : 6'h3F;
  assign irq_n = ~(irq_on && irq_code[5:3] != 3'h0 && prio_chain[irq_code[5:3]]);
  assign pf_n = ~pf_low;
  // Released bus shows the inverse, never a stale copy
  assign bus = (in_stb && sel_high_n != 8'hFF) ? DEV_DATA : ~DEV_DATA;
endmodule

`default_nettype wire

/* File: sim/multiplexed_io_controller_bench.sv */
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin num_errors++; \
  $display("mismatch t=%0t got %h exp %h", $time, g, e); end end

module multiplexed_io_controller_bench;
  logic CLOCK = 0, RST = 1, grp = 0, i_out = 0, i_in = 0, i_clc = 0, ce = 1, btn = 0;
  logic int_ph = 0, run_mode = 0, pwr_ok = 1, irq_on = 0, pf_low = 0;
  logic [5:0] sel = 6'h00, code = 6'h00, vec_n, int_addr;
  logic [2:0] phase = 3'h0;
  logic [15:0] dout = 16'h0000, bus_i, bus_o;
  logic [7:0] hi_n, lo_n;
  logic irq_n, pf_n, out_stb, in_stb, oe, ctl_rst, preset, run, pwr_on;
  logic int_valid, irq_pend, pf_halt, restart_en, io_group_strobe;
  int num_errors = 0, n_checks = 0, cycles = 0;

  always #5 CLOCK = ~CLOCK;

  mio_ctl mio_ctl_inst (.CLOCK(CLOCK), .RST(RST), .CE(ce), .IO_GROUP(grp),
    .INSTR_OUT(i_out), .INSTR_IN(i_in), .INSTR_CLC(i_clc), .SEL_CODE(sel),
    .PHASE(phase), .INT_PHASE(int_ph), .RUN_MODE(run_mode), .POWER_OK(pwr_ok),
    .CPU_DATA_OUT(dout), .PRESET_BUTTON(btn), .IO_BUS_I(bus_i),
    .IRQ_VECTOR_BITS_N(vec_n), .EXT_IRQ_REQUEST_N(irq_n), .EXT_POWER_FAIL_N(pf_n),
    .SELECT_HIGH_DIGIT_N(hi_n), .SELECT_LOW_DIGIT_N(lo_n), .IO_GROUP_STROBE(io_group_strobe),
    .OUTPUT_STROBE(out_stb), .INPUT_STROBE(in_stb), .IO_BUS_O(bus_o), .IO_BUS_OE(oe),
    .CONTROL_RESET(ctl_rst), .PRESET_PULSE(preset), .RUN(run), .POWER_ON(pwr_on),
    .INT_ADDR(int_addr), .INT_VALID(int_valid), .IRQ_PENDING(irq_pend),
    .PF_HALT(pf_halt), .AUTO_RESTART_EN(restart_en));

  mio_partner mio_partner_inst (.in_stb(in_stb), .sel_high_n(hi_n), .irq_code(code),
    .irq_on(irq_on), .pf_low(pf_low), .vec_n(vec_n), .irq_n(irq_n), .pf_n(pf_n),
    .bus(bus_i));

  task automatic cyc(input int n);
    repeat (n) @(negedge CLOCK);
  endtask

  task automatic t_out;
    grp = 1; i_out = 1; sel = 6'o47; dout = 16'h5A3C;
    for (int p = 3; p <= 6; p++) begin
      phase = p[2:0];
      cyc(1);
      `CHK(out_stb, p != 6)
      `CHK(oe, p != 6)
      if (p == 3) begin
        `CHK(bus_o, 16'h5A3C)
        `CHK(hi_n, 8'hEF)
        `CHK(lo_n, 8'h7F)
        `CHK(io_group_strobe, 1'b1)
      end
    end
    grp = 0; i_out = 0;
    cyc(1);
    `CHK(hi_n, 8'hFF)
    `CHK(io_group_strobe, 1'b0)
  endtask

  task automatic t_clc;
    grp = 1; i_clc = 1; sel = 6'o00;
    cyc(1);
    `CHK(ctl_rst, 1'b1)
    sel = 6'o10;
    cyc(1);
    `CHK(ctl_rst, 1'b0)
    sel = 6'o00; grp = 0;
    cyc(1);
    `CHK(ctl_rst, 1'b0)
    i_clc = 0;
  endtask

  task automatic t_irq;
    code = 6'o56; irq_on = 1;
    cyc(3);
    int_ph = 1;
    cyc(1);
    int_ph = 0;
    `CHK(irq_pend, 1'b1)
    `CHK(int_valid, 1'b1)
    `CHK(int_addr, 6'h2E)
    cyc(1);
    `CHK(int_valid, 1'b0)
    `CHK(int_addr, 6'h2E)
    code = 6'o05;
    cyc(4);
    `CHK(irq_pend, 1'b0)
    irq_on = 0;
  endtask

  task automatic t_pwr;
    pwr_ok = 0; run_mode = 1;
    cyc(2);
    `CHK(preset, 1'b1)
    `CHK(pwr_on, 1'b0)
    `CHK(run, 1'b1)
    cyc(5);
    `CHK(preset, 1'b0)
    pwr_ok = 1; run_mode = 0;
    cyc(2);
    `CHK(preset, 1'b1)
    `CHK(pwr_on, 1'b1)
    `CHK(run, 1'b0)
    cyc(5);
    btn = 1;
    cyc(4);
    `CHK(preset, 1'b1)
    btn = 0;
    cyc(5);
    `CHK(preset, 1'b0)
    ce = 0; run_mode = 1;
    cyc(2);
    `CHK(run, 1'b0)
    ce = 1;
    cyc(1);
    `CHK(run, 1'b1)
    run_mode = 0;
  endtask

  task automatic t_pf;
    pf_low = 1;
    cyc(4);
    `CHK(pf_halt, 1'b1)
    `CHK(restart_en, 1'b0)
    pf_low = 0;
    cyc(4);
    `CHK(restart_en, 1'b1)
  endtask

  task automatic t_in;
    grp = 1; i_in = 1; sel = 6'o21; phase = 3'h3;
    cyc(1);
    `CHK(in_stb, 1'b1)
    `CHK(oe, 1'b0)
    // Bus needs two sync stages to settle before phase five samples it
    phase = 3'h4;
    cyc(2);
    phase = 3'h5;
    cyc(2);
    phase = 3'h6; i_in = 0; grp = 0;
    cyc(2);
    `CHK(in_stb, 1'b0)
    `CHK(mio_ctl_inst.st.cpu_din, 16'hC35A)
  endtask

  task automatic complete_run;
    $display("checks %0d errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  // Whole sequence needs under 150 cycles
  always @(posedge CLOCK) begin
    cycles <= cycles + 1;
    if (cycles == 2000) begin
      num_errors++;
      complete_run();
    end
  end

  initial begin
    cyc(2);
    RST = 0;
    cyc(7);
    `CHK(hi_n, 8'hFF)
    `CHK(restart_en, 1'b1)
    `CHK(out_stb, 1'b0)
    t_out();
    t_clc();
    t_irq();
    t_pwr();
    t_pf();
    t_in();
    complete_run();
  end
endmodule

`default_nettype wire
